/* File: common/lpm_pkg.sv */
// Constants, states and behaviour list for the low-power mode controller
// Operation
// [RULE_01] Idle starts only after the instruction setting the idle bit completes.
// [RULE_02] Idle gates the core clock; interrupts, timers and serial keep running.
// [RULE_03] Idle keeps every core register at its entry value.
// [RULE_04] Idle freezes each port pin at the level driven on entry. Code freezes ports 1-3 only; port 0 floats (p0_oe low).
// [RULE_05] An enabled interrupt in idle clears the idle bit and resumes.
// [RULE_06] Reset must be held 24 oscillator periods to end idle.
// [RULE_07] Power-down stops the oscillator after the requesting instruction.
// [RULE_08] Power-down keeps internal memory and special registers unchanged.
// [RULE_09] Only reset or an enabled external interrupt ends power-down.
// [RULE_10] Wake signals wait for supply and hold until oscillator is stable.
// [RULE_11] Low enabled pin restarts oscillator; its release completes the exit.
// [RULE_12] Either low pin restarts; first release exits; higher priority serviced.
// [RULE_13] Return from the wake interrupt continues after the power-down instruction.
// [RULE_14] Reset exit reinitialises special registers; interrupt exit leaves them.
// [RULE_15] No power-down exit alters internal data memory.
// [RULE_16] Both bits set: power-down exit; vectoring clears both, no idle.
// [RULE_17] Idle: both strobes high, port 0 floats, ports keep data/address.
// [RULE_18] Power-down: both strobes low, port 0 floats, port latches held.
// [RULE_19] Emulation entry: strobe low during reset with fetch strobe high.
// [RULE_20] Emulation: strobes and ports 1-3 weak pull-up, port 0 floats.
// [RULE_21] A normal reset leaves emulation mode.
// [RULE_22] Power-down bit is bit 1; reset clears it.
// [RULE_23] Clockless low detection on external pins starts oscillator restart.
package lpm_pkg;

  // ------------------------------------------------------------
  // Power control register layout
  // ------------------------------------------------------------
  localparam int         IDL_BIT    = 0;
  localparam int         PD_BIT     = 1;
  localparam logic [7:0] POWER_CONTROL_REG_RST   = 8'h10;
  localparam logic [7:0] POWER_CONTROL_REG_WMASK = 8'hdf;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int OSC_PERIOD_NS  = 100;
  localparam int RESET_HOLD_OSC = 24;
  localparam int RESET_HOLD_CYC =
    (RESET_HOLD_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 8;
  localparam int OSC_STABLE_DEF = 64;

  // ------------------------------------------------------------
  // Mode states
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RUN      = 5'h01,
    ST_IDLE     = 5'h02,
    ST_PD_SLEEP = 5'h04,
    ST_PD_WAKE  = 5'h08,
    ST_EMUL     = 5'h10
  } lpm_state_e;

endpackage

/* File: design/hold_counter.sv */
// Saturating cycle counter that flags a level held for LIMIT cycles
`timescale 1ns/1ps
`default_nettype none
module hold_counter #(
  parameter int             W     = 8,
  parameter logic [W-1:0]   LIMIT = 8'h18
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  input  wire logic count,
  output logic      done
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (!count) begin
        cnt_r <= '0;
      end else if (cnt_r != LIMIT) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign done = count && (cnt_r == LIMIT);
endmodule
`default_nettype wire

/* File: design/pin_latch.sv */
// Port level and drive latch, frozen while load is low
`timescale 1ns/1ps
`default_nettype none
module pin_latch #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (clk_en && load) begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

/* File: design/low_power_mode_control.sv */
// Idle, power-down and emulation mode control with pin sequencing
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_control #(
  parameter int OSC_STABLE_CYC = lpm_pkg::OSC_STABLE_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       rst_pin,
  input  wire logic       power_control_reg_wr,
  input  wire logic [7:0] power_control_reg_wdata,
  output logic      [7:0] power_control_reg_rdata,
  input  wire logic       irq_pending,
  input  wire logic       irq_vector,
  input  wire logic       ex0_en,
  input  wire logic       ex1_en,
  input  wire logic       x1_prio_hi,
  input  wire logic       ext_irq_zero_b,
  input  wire logic       ext_irq_one_b,
  output logic            core_clk_en,
  output logic            periph_clk_en,
  output logic            osc_run,
  output logic            state_hold,
  output logic            sfr_reset,
  output logic            wake_irq,
  output logic            wake_src,
  output logic            emul_mode,
  input  wire logic       core_ale,
  input  wire logic       core_program_fetch_strobe,
  input  wire logic       ale_in,
  input  wire logic       program_fetch_strobe_in,
  output logic            ale_o,
  output logic            ale_oe,
  output logic            program_fetch_strobe_o,
  output logic            program_fetch_strobe_oe,
  output logic            pullup_en,
  input  wire logic       core_p0_oe,
  output logic            p0_oe,
  input  wire logic [7:0] core_p1,
  input  wire logic [7:0] core_p1_oe,
  input  wire logic [7:0] core_p2,
  input  wire logic [7:0] core_p2_oe,
  input  wire logic [7:0] p2_sfr,
  input  wire logic [7:0] core_p3,
  input  wire logic [7:0] core_p3_oe,
  output logic      [7:0] p1_o,
  output logic      [7:0] p1_oe,
  output logic      [7:0] p2_o,
  output logic      [7:0] p2_oe,
  output logic      [7:0] p3_o,
  output logic      [7:0] p3_oe
);
  import lpm_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  lpm_state_e  state_r;
  lpm_state_e  state_nxt;
  logic [7:0]  power_control_reg_r;
  logic [7:0]  power_control_reg_nxt;
  logic        rst_act;
  logic        rst_act_r;
  logic        rst_fall;
  logic        emul_arm_r;
  logic        osc_stable;
  logic        osc_wake;
  logic [1:0]  low_now;
  logic [1:0]  low_seen_r;
  logic        released_r;
  logic        wake_irq_r;
  logic        wake_src_r;
  logic        in_run;
  logic        in_idle;
  logic        in_pd;
  logic        req_pd;
  logic        req_idl;
  logic [15:0] p1_q;
  logic [15:0] p2_q;
  logic [15:0] p3_q;
  logic [7:0]  p2_src;

  // The edge that sees the last held cycle already qualifies the reset
  localparam logic [CNT_W-1:0] RST_LIMIT = CNT_W'(RESET_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] OSC_LIMIT = CNT_W'(OSC_STABLE_CYC);

  assign in_run  = (state_r == ST_RUN);
  assign in_idle = (state_r == ST_IDLE);
  assign in_pd   = (state_r == ST_PD_SLEEP) || (state_r == ST_PD_WAKE);
  assign req_pd  = power_control_reg_wr && power_control_reg_wdata[PD_BIT];
  assign req_idl = power_control_reg_wr && power_control_reg_wdata[IDL_BIT];

  // ------------------------------------------------------------
  // Hardware reset qualification
  // ------------------------------------------------------------
  // Short glitches on the reset pin never reach the core
  hold_counter #(.W(CNT_W), .LIMIT(RST_LIMIT)) u_rst_hold (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .count   (rst_pin),
    .done    (rst_act)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_act_r <= 1'b0;
    end else if (clk_en) begin
      rst_act_r <= rst_act || (rst_act_r && rst_pin);
    end
  end

  assign rst_fall  = rst_act_r && !rst_pin;
  assign sfr_reset = rst_act_r;  // see [RULE_14] see [RULE_06]

  // Emulation entry armed while in reset with strobe low, fetch strobe high
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      emul_arm_r <= 1'b0;
    end else if (clk_en) begin
      if (!rst_act_r) begin
        emul_arm_r <= 1'b0;
      end else if (!ale_in && program_fetch_strobe_in) begin
        emul_arm_r <= 1'b1;  // see [RULE_19]
      end else if (ale_in) begin
        emul_arm_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Clockless wake detection
  // ------------------------------------------------------------
  // Must work with the oscillator stopped, so no flop in this path
  assign low_now  = {ex1_en && !ext_irq_one_b, ex0_en && !ext_irq_zero_b};
  assign osc_wake = |low_now;  // see [RULE_23] see [RULE_09]
  assign osc_run  = (state_r != ST_PD_SLEEP) || osc_wake || rst_pin;  // see [RULE_07] see [RULE_11]

  hold_counter #(.W(CNT_W), .LIMIT(OSC_LIMIT)) u_osc_hold (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .count   (state_r == ST_PD_WAKE),
    .done    (osc_stable)
  );

  // ------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN: begin
        if (req_pd) begin
          state_nxt = ST_PD_SLEEP;  // see [RULE_07] see [RULE_16]
        end else if (req_idl) begin
          state_nxt = ST_IDLE;  // see [RULE_01]
        end
      end
      ST_IDLE: begin
        if (irq_pending) begin
          state_nxt = ST_RUN;  // see [RULE_05]
        end
      end
      ST_PD_SLEEP: begin
        if (osc_wake) begin
          state_nxt = ST_PD_WAKE;  // see [RULE_11] see [RULE_12]
        end
      end
      ST_PD_WAKE: begin
        if (osc_stable && released_r) begin
          state_nxt = ST_RUN;
        end
      end
      ST_EMUL: begin
        state_nxt = ST_EMUL;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    if (rst_fall) begin
      state_nxt = emul_arm_r && !ale_in ? ST_EMUL : ST_RUN;  // see [RULE_19] see [RULE_21]
    end else if (rst_act_r) begin
      state_nxt = ST_RUN;  // see [RULE_09]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_RUN;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // Power-down wake source tracking
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_seen_r <= 2'h0;
      released_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r == ST_PD_SLEEP) begin
        low_seen_r <= low_now;
        released_r <= 1'b0;
      end else if (state_r == ST_PD_WAKE) begin
        low_seen_r <= low_seen_r | low_now;
        if (|(low_seen_r & ~low_now)) begin
          released_r <= 1'b1;  // see [RULE_12]
        end
      end
    end
  end

  // Higher priority pin wins when both pulled the device awake
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_irq_r <= 1'b0;
      wake_src_r <= 1'b0;
    end else if (clk_en) begin
      wake_irq_r <= (state_r == ST_PD_WAKE) && (state_nxt == ST_RUN);  // see [RULE_13]
      if ((state_r == ST_PD_WAKE) && (state_nxt == ST_RUN)) begin
        wake_src_r <= (&low_seen_r) ? x1_prio_hi : low_seen_r[1];  // see [RULE_12]
      end
    end
  end

  assign wake_irq = wake_irq_r;
  assign wake_src = wake_src_r;

  // ------------------------------------------------------------
  // Power control register
  // ------------------------------------------------------------
  always_comb begin
    power_control_reg_nxt = power_control_reg_r;
    if (in_idle && irq_pending) begin
      power_control_reg_nxt[IDL_BIT] = 1'b0;  // see [RULE_05]
    end
    if (irq_vector) begin
      power_control_reg_nxt[IDL_BIT] = 1'b0;  // see [RULE_16]
      power_control_reg_nxt[PD_BIT]  = 1'b0;
    end
    if (power_control_reg_wr) begin
      power_control_reg_nxt = power_control_reg_wdata & POWER_CONTROL_REG_WMASK;
    end
    if (rst_act_r) begin
      power_control_reg_nxt[IDL_BIT] = 1'b0;  // see [RULE_22]
      power_control_reg_nxt[PD_BIT]  = 1'b0;
    end
  end

  // Warm reset keeps the power-off flag; only rst_b restores it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_control_reg_r <= POWER_CONTROL_REG_RST;
    end else if (clk_en) begin
      power_control_reg_r <= power_control_reg_nxt;
    end
  end

  assign power_control_reg_rdata = power_control_reg_r;

  // ------------------------------------------------------------
  // Clock gating and retention
  // ------------------------------------------------------------
  assign core_clk_en   = in_run || (state_r == ST_EMUL);  // see [RULE_02]
  assign periph_clk_en = !in_pd;  // see [RULE_02]
  assign state_hold    = in_idle || in_pd;  // see [RULE_03] see [RULE_08] see [RULE_15]
  assign emul_mode     = (state_r == ST_EMUL);

  // ------------------------------------------------------------
  // Pin control
  // ------------------------------------------------------------
  // Port 2 shows its data latch, not the bus address, in power-down
  assign p2_src = req_pd ? p2_sfr : core_p2;

  pin_latch #(.W(16)) u_p1 (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .load    (in_run),
    .d       ({core_p1_oe, core_p1}),
    .q       (p1_q)
  );  // see [RULE_04]

  pin_latch #(.W(16)) u_p2 (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .load    (in_run),
    .d       ({core_p2_oe, p2_src}),
    .q       (p2_q)
  );  // see [RULE_17] see [RULE_18]

  pin_latch #(.W(16)) u_p3 (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .load    (in_run),
    .d       ({core_p3_oe, core_p3}),
    .q       (p3_q)
  );

  assign p1_o  = p1_q[7:0];
  assign p2_o  = p2_q[7:0];
  assign p3_o  = p3_q[7:0];
  assign p1_oe = emul_mode ? 8'h00 : p1_q[15:8];  // see [RULE_20]
  assign p2_oe = emul_mode ? 8'h00 : p2_q[15:8];
  assign p3_oe = emul_mode ? 8'h00 : p3_q[15:8];

  assign p0_oe     = in_run && core_p0_oe;  // see [RULE_17] see [RULE_18]
  assign ale_o     = in_idle || (in_run && core_ale);  // see [RULE_17] see [RULE_18]
  assign program_fetch_strobe_o    = in_idle || (in_run && core_program_fetch_strobe);
  assign ale_oe    = !emul_mode;  // see [RULE_20]
  assign program_fetch_strobe_oe   = !emul_mode;
  assign pullup_en = emul_mode;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_idle_req;
    clk_en && in_run && req_idl && !req_pd && !rst_act_r;
  endsequence

  a_idle_entry_gate: assert property (s_idle_req |=> in_idle && !core_clk_en && periph_clk_en) // see [RULE_02]
    else $error("idle entry did not gate the core clock");

  a_idle_wake_clear: assert property (clk_en && in_idle && irq_pending && !power_control_reg_wr && !rst_act_r
    |=> in_run && !power_control_reg_r[IDL_BIT]) // see [RULE_05]
    else $error("idle wake did not clear the idle bit");

  a_port_freeze: assert property ((in_idle || in_pd) && $past(in_idle || in_pd)
    |-> $stable(p1_o) && $stable(p3_o) && $stable(p2_o)) // see [RULE_04]
    else $error("port pins moved during a low-power mode");

  a_idle_strobes: assert property (in_idle |-> ale_o && program_fetch_strobe_o && ale_oe && !p0_oe) // see [RULE_17]
    else $error("idle strobe levels wrong");

  a_pd_strobes: assert property (in_pd |-> !ale_o && !program_fetch_strobe_o && program_fetch_strobe_oe && !p0_oe) // see [RULE_18]
    else $error("power-down strobe levels wrong");

  a_pd_osc_stop: assert property (state_r == ST_PD_SLEEP && !osc_wake && !rst_pin |-> !osc_run) // see [RULE_07]
    else $error("oscillator running in power-down");

  a_pd_restart: assert property (clk_en && state_r == ST_PD_SLEEP && osc_wake && !rst_act_r
    |-> osc_run ##1 state_r == ST_PD_WAKE) // see [RULE_11]
    else $error("low wake pin did not restart oscillator");

  a_vector_clear: assert property (clk_en && irq_vector && !power_control_reg_wr
    |=> !power_control_reg_r[IDL_BIT] && !power_control_reg_r[PD_BIT]) // see [RULE_16]
    else $error("vectoring did not clear both request bits");

  a_reset_clear: assert property (clk_en && rst_act_r |=> !power_control_reg_r[PD_BIT] && !in_pd) // see [RULE_22]
    else $error("reset left power-down set");

  a_emul_float: assert property (emul_mode |-> !ale_oe && !program_fetch_strobe_oe && pullup_en && p1_oe == 8'h00
    && !p0_oe) // see [RULE_20]
    else $error("emulation pins not released");
endmodule
`default_nettype wire

/* File: test/ext_partner.sv */
// Far-side model: reset source, external interrupt pins and emulation tester
`timescale 1ns/1ps
`default_nettype none
module ext_partner (
  input  wire logic ref_clk,
  input  wire logic ale_o,
  input  wire logic ale_oe,
  input  wire logic program_fetch_strobe_o,
  input  wire logic program_fetch_strobe_oe,
  output logic      rst_pin,
  output logic      ext_irq_zero_b,
  output logic      ext_irq_one_b,
  output logic      ale_in,
  output logic      program_fetch_strobe_in
);
  logic ale_pull_low;

  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  // Tester overpowers the strobe; released strobes rest on their pull-ups
  assign ale_in  = ale_pull_low ? 1'b0 : (ale_oe ? ale_o : 1'b1);
  assign program_fetch_strobe_in = program_fetch_strobe_oe ? program_fetch_strobe_o : 1'b1;

  initial begin
    rst_pin        = 1'b0;
    ext_irq_zero_b = 1'b1;
    ext_irq_one_b  = 1'b1;
    ale_pull_low   = 1'b0;
  end

  // ----------------------------------------
  // Actions
  // ----------------------------------------
  task automatic hold_reset(input int n);
    @(negedge ref_clk);
    rst_pin = 1'b1;
    repeat (n) @(negedge ref_clk);
    rst_pin = 1'b0;
  endtask

  // Caller keeps the level long enough for the oscillator to settle
  task automatic set_irq(input logic sel, input logic lvl);
    if (sel) begin
      ext_irq_one_b = lvl;
    end else begin
      ext_irq_zero_b = lvl;
    end
  endtask

  // Strobe held low across the reset release
  task automatic emul_entry();
    ale_pull_low = 1'b1;
    hold_reset(30);
    repeat (3) @(negedge ref_clk);
    ale_pull_low = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/low_power_mode_control_test.sv */
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_control_test;
  import lpm_pkg::*;
  localparam int STABLE = 4;
  logic       ref_clk = 1'b0;
  logic       rst_b, clk_en, power_control_reg_wr, irq_pending, irq_vector, ex0_en, ex1_en, x1_prio_hi;
  logic       core_ale, core_program_fetch_strobe, core_p0_oe, rst_pin, ext_irq_zero_b, ext_irq_one_b;
  logic       ale_in, program_fetch_strobe_in, core_clk_en, periph_clk_en, osc_run, state_hold, sfr_reset;
  logic       wake_irq, wake_src, emul_mode, ale_o, ale_oe, program_fetch_strobe_o, program_fetch_strobe_oe, pullup_en, p0_oe;
  logic [7:0] power_control_reg_wdata, power_control_reg_rdata, core_p1, core_p1_oe, core_p2, core_p2_oe, p2_sfr;
  logic [7:0] core_p3, core_p3_oe, p1_o, p1_oe, p2_o, p2_oe, p3_o, p3_oe;
  int         n_errors = 0;
  int         comparisons = 0;

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  low_power_mode_control #(.OSC_STABLE_CYC(STABLE)) i_low_power_mode_control (
    .ref_clk, .rst_b, .clk_en, .rst_pin, .power_control_reg_wr, .power_control_reg_wdata, .power_control_reg_rdata, .irq_pending,
    .irq_vector, .ex0_en, .ex1_en, .x1_prio_hi, .ext_irq_zero_b, .ext_irq_one_b, .core_clk_en,
    .periph_clk_en, .osc_run, .state_hold, .sfr_reset, .wake_irq, .wake_src, .emul_mode,
    .core_ale, .core_program_fetch_strobe, .ale_in, .program_fetch_strobe_in, .ale_o, .ale_oe, .program_fetch_strobe_o, .program_fetch_strobe_oe, .pullup_en,
    .core_p0_oe, .p0_oe, .core_p1, .core_p1_oe, .core_p2, .core_p2_oe, .p2_sfr, .core_p3,
    .core_p3_oe, .p1_o, .p1_oe, .p2_o, .p2_oe, .p3_o, .p3_oe);

  ext_partner i_ext_partner (
    .ref_clk, .ale_o, .ale_oe, .program_fetch_strobe_o, .program_fetch_strobe_oe, .rst_pin, .ext_irq_zero_b, .ext_irq_one_b,
    .ale_in, .program_fetch_strobe_in);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic power_control_reg_write(input logic [7:0] d);
    power_control_reg_wr = 1'b1;
    power_control_reg_wdata = d;
    @(negedge ref_clk);
    power_control_reg_wr = 1'b0;
  endtask

  task automatic pulse_vec;
    irq_vector = 1'b1;
    @(negedge ref_clk);
    irq_vector = 1'b0;
  endtask

  // Counts the reset window plus margin; short pulses must leave no trace
  task automatic pulse_rst(input int n, input logic exp);
    logic seen;
    seen = 1'b0;
    fork i_ext_partner.hold_reset(n); join_none
    repeat (n + 4) begin
      @(negedge ref_clk);
      seen = seen | sfr_reset;
    end
    chk("sfr_reset seen", exp, seen);
  endtask

  task automatic wait_wake(input logic src);
    int i;
    for (i = 0; i < 40 && wake_irq !== 1'b1; i++) @(negedge ref_clk);
    if (wake_irq !== 1'b1) begin
      n_errors++;
      $display("BAD wake_irq expected 1 seen %b", wake_irq);
      end_of_test();
    end
    chk("wake_src", src, wake_src);
    chk("wake core_clk_en", 1, core_clk_en);
    chk("wake pd bit kept", 1, power_control_reg_rdata[PD_BIT]);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_idle;
    core_p1 = 8'ha5;
    core_p2 = 8'h3c;
    power_control_reg_write(8'h01);
    chk("idle core_clk_en", 0, core_clk_en);
    chk("idle periph_clk_en", 1, periph_clk_en);
    chk("idle state_hold", 1, state_hold);
    chk("idle strobes", 8'h03, {ale_o, program_fetch_strobe_o});
    chk("idle p0_oe", 0, p0_oe);
    core_p1 = 8'h5a;
    core_p2 = 8'hc3;
    core_p3 = 8'h11;
    core_p1_oe = 8'h0f;
    core_p2_oe = 8'hf0;
    @(negedge ref_clk);
    chk("idle p1_o", 8'ha5, p1_o);
    chk("idle p1_oe", 8'hff, p1_oe);
    chk("idle p3_o", 8'h77, p3_o);
    chk("idle p2_o", 8'h3c, p2_o);
    irq_pending = 1'b1;
    @(negedge ref_clk);
    irq_pending = 1'b0;
    chk("irq wake core_clk_en", 1, core_clk_en);
    chk("irq wake idle bit", 0, power_control_reg_rdata[IDL_BIT]);
    power_control_reg_write(8'h01);
    pulse_rst(RESET_HOLD_CYC - 1, 1'b0);
    chk("short reset core_clk_en", 0, core_clk_en);
    pulse_rst(RESET_HOLD_CYC, 1'b1);
    chk("reset wake core_clk_en", 1, core_clk_en);
    chk("reset power_control_reg bits", 0, power_control_reg_rdata[1:0]);
    $display("test idle done");
  endtask

  task automatic t_powerdown;
    ex1_en = 1'b1;
    x1_prio_hi = 1'b1;
    p2_sfr = 8'h96;
    power_control_reg_write(8'h02);
    p2_sfr = 8'h00;
    chk("pd osc_run", 0, osc_run);
    chk("pd periph_clk_en", 0, periph_clk_en);
    chk("pd strobes", 0, {ale_o, program_fetch_strobe_o});
    chk("pd p0_oe", 0, p0_oe);
    @(negedge ref_clk);
    chk("pd p2_o", 8'h96, p2_o);
    chk("pd state_hold", 1, state_hold);
    i_ext_partner.set_irq(1'b0, 1'b0);
    #1 chk("pd disabled pin", 0, osc_run);
    i_ext_partner.set_irq(1'b0, 1'b1);
    @(negedge ref_clk);
    i_ext_partner.set_irq(1'b1, 1'b0);
    #1 chk("pd restart", 1, osc_run);
    repeat (STABLE + 4) @(negedge ref_clk);
    chk("pd held low", 0, core_clk_en);
    i_ext_partner.set_irq(1'b1, 1'b1);
    wait_wake(1'b1);
    pulse_vec();
    chk("vector power_control_reg bits", 0, power_control_reg_rdata[1:0]);
    $display("test power-down done");
  endtask

  task automatic t_both;
    ex0_en = 1'b1;
    x1_prio_hi = 1'b0;
    power_control_reg_write(8'h03);
    chk("both osc_run", 0, osc_run);
    chk("both strobes", 0, {ale_o, program_fetch_strobe_o});
    i_ext_partner.set_irq(1'b0, 1'b0);
    i_ext_partner.set_irq(1'b1, 1'b0);
    #1 chk("both restart", 1, osc_run);
    repeat (STABLE + 4) @(negedge ref_clk);
    i_ext_partner.set_irq(1'b0, 1'b1);
    wait_wake(1'b0);
    i_ext_partner.set_irq(1'b1, 1'b1);
    pulse_vec();
    repeat (2) @(negedge ref_clk);
    chk("both power_control_reg bits", 0, power_control_reg_rdata[1:0]);
    chk("both no idle", 1, core_clk_en);
    power_control_reg_write(8'h02);
    chk("pd again osc_run", 0, osc_run);
    pulse_rst(RESET_HOLD_CYC, 1'b1);
    chk("pd reset exit", 1, core_clk_en);
    chk("pd reset pd bit", 0, power_control_reg_rdata[PD_BIT]);
    $display("test both bits done");
  endtask

  task automatic t_emul;
    i_ext_partner.emul_entry();
    chk("emul_mode", 1, emul_mode);
    chk("emul strobe oe", 0, {ale_oe, program_fetch_strobe_oe});
    chk("emul pullup_en", 1, pullup_en);
    chk("emul port oe", 0, p1_oe | p2_oe | p3_oe);
    chk("emul p0_oe", 0, p0_oe);
    chk("emul osc_run", 1, osc_run);
    pulse_rst(RESET_HOLD_CYC + 2, 1'b1);
    chk("emul left", 0, emul_mode);
    $display("test emulation done");
  endtask

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    power_control_reg_wr = 1'b0;
    power_control_reg_wdata = 8'h00;
    irq_pending = 1'b0;
    irq_vector = 1'b0;
    ex0_en = 1'b0;
    ex1_en = 1'b0;
    x1_prio_hi = 1'b0;
    core_ale = 1'b1;
    core_program_fetch_strobe = 1'b1;
    core_p0_oe = 1'b1;
    core_p1 = 8'h00;
    core_p1_oe = 8'hff;
    core_p2 = 8'h00;
    core_p2_oe = 8'hff;
    p2_sfr = 8'h00;
    core_p3 = 8'h77;
    core_p3_oe = 8'h0f;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    chk("reset power_control_reg", POWER_CONTROL_REG_RST, power_control_reg_rdata);
    clk_en = 1'b0;
    power_control_reg_write(8'h01);
    chk("frozen power_control_reg", POWER_CONTROL_REG_RST, power_control_reg_rdata);
    chk("frozen core_clk_en", 1, core_clk_en);
    clk_en = 1'b1;
    t_idle();
    t_powerdown();
    t_both();
    t_emul();
    end_of_test();
  end
endmodule
`default_nettype wire
